// ### pec_regs.svh
// Purpose: Offsets, field positions, reset values and event codes of the
//          performance event counter bank.
// Assumes: 32-bit APB data, one register per aligned word.
// Notes:   Definitions only.
//
// Function
// - Event code 0x08 counts untagged retired native-set instructions; the code also counts lanes retired under the legacy set when run_legacy is set.
// - Event code 0x12 counts running processor clock cycles.
// - Every event counter has 32 counting bits and wraps beyond them.
// - Exactly four generic counters, each a configuration plus a count register.
// - Configuration registers 0 to 13 exist, matching mask 0x3fff.
// - Count registers 0 to 17 exist, matching mask 0x3ffff.
// - Only counters 4 to 7, mask 0xf0, may count running cycles.
// - Only counter 4, mask 0x10, may count untagged retired instructions.
// - Retired count includes predicated-off and nop, excludes stack engine operations.
// - Events are qualified by the instruction set now executing: native, legacy, both.
// - A 4-bit unit mask picks the event variant; don't-care bits are ignored.
`ifndef PEC_REGS_SVH
`define PEC_REGS_SVH

// ----------------------------------------------------------------------
// Event codes and counter bank shape
// ----------------------------------------------------------------------
`define PEC_EV_RETIRED 8'h08
`define PEC_EV_CYCLES 8'h12
`define PEC_CNT_W 32
`define PEC_NUM_CNT 4
`define PEC_FIRST_CNT 4
`define PEC_NUM_CFG 14
`define PEC_NUM_DAT 18
`define PEC_CFG_POP 32'h0000_3fff
`define PEC_DAT_POP 32'h0003_ffff
`define PEC_CYC_MASK 8'hf0
`define PEC_RET_MASK 8'h10

// ----------------------------------------------------------------------
// Address map (byte addresses)
// ----------------------------------------------------------------------
`define PEC_ADDR_W 12
`define PEC_REGION_CFG 4'h0
`define PEC_REGION_DAT 4'h1

// ----------------------------------------------------------------------
// Global control register (configuration index 0)
// ----------------------------------------------------------------------
`define PEC_CTL_IDX 6'h00
`define PEC_CTL_FREEZE_BIT 0
`define PEC_CTL_OVF_LSB 4
`define PEC_RST_WORD 32'h0000_0000

`endif

// ### pec_pkg.sv
// Purpose: Types shared by the event counter bank and its counters.
// Assumes: Nothing beyond SystemVerilog packed types.
// Notes:   Layout of a counter configuration word.
package pec_pkg;

	typedef struct packed {
		logic [12:0] spare;
		logic run_legacy;
		logic run_native;
		logic enable;
		logic [3:0] care;
		logic [3:0] umask;
		logic [7:0] code;
	} pec_cfg_s;

endpackage

// ### pec_cnt_if.sv
// Purpose: Connects the bank control logic to one event counter.
// Assumes: Same clock on both sides.
// Notes:   Event inputs are broadcast to all counters.
`timescale 1ns/10ps
interface pec_cnt_if #(
	parameter int CW = 32,
	parameter int RW = 3
);
	import pec_pkg::*;
	pec_cfg_s cfg;
	logic freeze;
	logic wr_en;
	logic [CW-1:0] wr_data;
	logic cyc;
	logic legacy;
	logic [RW-1:0] retired;
	logic gen_valid;
	logic [7:0] gen_code;
	logic [3:0] gen_umask;
	logic [CW-1:0] count;
	logic wrap;

	modport ctl (
		output cfg, freeze, wr_en, wr_data, cyc, legacy, retired,
		output gen_valid, gen_code, gen_umask,
		input count, wrap
	);
	modport cnt (
		input cfg, freeze, wr_en, wr_data, cyc, legacy, retired,
		input gen_valid, gen_code, gen_umask,
		output count, wrap
	);
endinterface

// ### pec_counter.sv
// Purpose: One generic event counter with its event selection.
// Assumes: Event inputs come from logic on pclk.
// Notes:   Capability bits gate which basic events this counter may take.
`timescale 1ns/10ps
`include "pec_regs.svh"
module pec_counter import pec_pkg::*; #(
	parameter int CW = 32,
	parameter int RW = 3,
	parameter bit CAN_CYC = 1'b0,
	parameter bit CAN_RET = 1'b0
) (
	input wire logic pclk,
	input wire logic presetn,
	pec_cnt_if.cnt bus
);

	typedef struct packed {
		logic [CW-1:0] count;
	} pec_cstate_s;

	pec_cstate_s st;
	pec_cstate_s next_st;
	logic [RW-1:0] occ;
	logic isa_ok;
	logic [CW:0] sum;

	always_comb begin
		next_st = st;
		occ = '0;
		case (bus.cfg.code)
			`PEC_EV_RETIRED: begin
				// Lane count already drops stack engine operations
				if (CAN_RET) begin
					occ = bus.retired;
				end
			end
			`PEC_EV_CYCLES: begin
				if (CAN_CYC) begin
					occ = RW'(bus.cyc);
				end
			end
			default: begin
				if (bus.gen_valid && bus.gen_code == bus.cfg.code &&
					((bus.gen_umask ^ bus.cfg.umask) & bus.cfg.care) == 4'h0) begin
					occ = RW'(1);
				end
			end
		endcase
		isa_ok = bus.legacy ? bus.cfg.run_legacy : bus.cfg.run_native;
		sum = {1'b0, st.count} + (CW+1)'(occ);
		bus.wrap = 1'b0;
		if (bus.cfg.enable && !bus.freeze && isa_ok) begin
			next_st.count = sum[CW-1:0];
			bus.wrap = sum[CW];
		end
		// A software write replaces the count, including this cycle's events,
		// so a wrap by those lost events must not raise the flag either
		if (bus.wr_en) begin
			next_st.count = bus.wr_data;
			bus.wrap = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign bus.count = st.count;

endmodule

// ### pec_bank.sv
// Purpose: Performance event counter bank behind an APB slave.
// Assumes: Event inputs come from core logic on pclk; no synchronisers.
// Notes:   Zero-wait APB; unmapped or unpopulated words answer pslverr.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "pec_regs.svh"
module pec_bank import pec_pkg::*; #(
	parameter int RETIRE_LANES = 6,
	parameter int CNT_W = `PEC_CNT_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [`PEC_ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic core_running,
	input wire logic core_legacy_isa,
	input wire logic [RETIRE_LANES-1:0] retire_valid,
	input wire logic [RETIRE_LANES-1:0] retire_rse,
	input wire logic evt_valid,
	input wire logic [7:0] evt_code,
	input wire logic [3:0] evt_umask
);

	// ----------------------------------------------------------------------
	// Local shapes
	// ----------------------------------------------------------------------
	localparam int RW = $clog2(RETIRE_LANES + 1);
	localparam int NC = `PEC_NUM_CNT;
	localparam int FC = `PEC_FIRST_CNT;
	localparam logic [7:0] CYC_MASK = `PEC_CYC_MASK;
	localparam logic [7:0] RET_MASK = `PEC_RET_MASK;
	localparam logic [31:0] CFG_POP = `PEC_CFG_POP;
	localparam logic [31:0] DAT_POP = `PEC_DAT_POP;

	typedef struct packed {
		logic [`PEC_NUM_CFG-1:0][31:0] cfg;
		logic [`PEC_NUM_DAT-1:0][31:0] dat;
		logic [NC-1:0] ovf;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} pec_state_s;

	pec_state_s st;
	pec_state_s next_st;

	// ----------------------------------------------------------------------
	// Retired instruction lane count
	// ----------------------------------------------------------------------
	// Predicated-off lanes and nops arrive as valid lanes and are kept;
	// only stack engine lanes are dropped.
	function automatic logic [RW-1:0] pec_popcount(
		input logic [RETIRE_LANES-1:0] v,
		input logic [RETIRE_LANES-1:0] register_stack_engine
	);
		logic [RW-1:0] n;
		n = '0;
		for (int k = 0; k < RETIRE_LANES; k++) begin
			if (v[k] && !register_stack_engine[k]) begin
				n = n + RW'(1);
			end
		end
		return n;
	endfunction

	logic [RW-1:0] retired_now;

	assign retired_now = pec_popcount(retire_valid, retire_rse);

	// ----------------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------------
	logic [3:0] region;
	logic [5:0] idx;
	logic setup;
	logic access;
	logic wr_access;
	logic is_cfg;
	logic is_dat;
	logic is_ctl;
	logic cnt_hit;
	logic [1:0] cnt_sel;
	logic mapped;

	assign region = paddr[11:8];
	assign idx = paddr[7:2];
	assign setup = psel && !penable;
	assign access = psel && penable && st.pready;
	assign wr_access = access && pwrite;

	always_comb begin
		is_cfg = 1'b0;
		is_dat = 1'b0;
		if (region == `PEC_REGION_CFG && idx < 6'(`PEC_NUM_CFG)) begin
			is_cfg = CFG_POP[idx[4:0]];
		end
		if (region == `PEC_REGION_DAT && idx < 6'(`PEC_NUM_DAT)) begin
			is_dat = DAT_POP[idx[4:0]];
		end
		is_ctl = is_cfg && idx == `PEC_CTL_IDX;
		cnt_hit = idx >= 6'(FC) && idx < 6'(FC + NC);
		cnt_sel = 2'(idx - 6'(FC));
		mapped = is_cfg || is_dat;
	end

	// ----------------------------------------------------------------------
	// Counter instances
	// ----------------------------------------------------------------------
	logic [NC-1:0][CNT_W-1:0] cnt_val;
	logic [NC-1:0] cnt_wrap;
	logic freeze;

	assign freeze = st.cfg[0][`PEC_CTL_FREEZE_BIT];

	pec_cnt_if #(.CW(CNT_W), .RW(RW)) cif[NC] ();

	for (genvar i = 0; i < NC; i++) begin : g_cnt
		// Counters sit at indices FC upward; their configuration words
		// live in the bank's own register array.
		assign cif[i].cfg = pec_cfg_s'(st.cfg[FC + i]);
		assign cif[i].freeze = freeze;
		assign cif[i].wr_en = wr_access && is_dat && cnt_hit && cnt_sel == 2'(i);
		assign cif[i].wr_data = CNT_W'(pwdata);
		assign cif[i].cyc = core_running;
		assign cif[i].legacy = core_legacy_isa;
		assign cif[i].retired = retired_now;
		assign cif[i].gen_valid = evt_valid;
		assign cif[i].gen_code = evt_code;
		assign cif[i].gen_umask = evt_umask;
		assign cnt_val[i] = cif[i].count;
		assign cnt_wrap[i] = cif[i].wrap;

		pec_counter #(
			.CW(CNT_W),
			.RW(RW),
			.CAN_CYC(CYC_MASK[FC + i]),
			.CAN_RET(RET_MASK[FC + i])
		) u_cnt (
			.pclk(pclk),
			.presetn(presetn),
			.bus(cif[i].cnt)
		);
	end

	// ----------------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------------
	logic [31:0] rd_word;

	always_comb begin
		rd_word = 32'h0000_0000;
		if (is_ctl) begin
			rd_word[`PEC_CTL_FREEZE_BIT] = freeze;
			rd_word[`PEC_CTL_OVF_LSB +: NC] = st.ovf;
		end else if (is_cfg) begin
			rd_word = st.cfg[idx[3:0]];
		end else if (is_dat && cnt_hit) begin
			rd_word = 32'(cnt_val[cnt_sel]);
		end else if (is_dat) begin
			rd_word = st.dat[idx[4:0]];
		end
	end

	// ----------------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------------
	always_comb begin
		next_st = st;

		// Answer one cycle after setup so every access has no wait state
		next_st.pready = setup;
		if (setup) begin
			next_st.prdata = pwrite ? 32'h0000_0000 : rd_word;
			next_st.pslverr = !mapped;
		end else if (access) begin
			next_st.prdata = 32'h0000_0000;
			next_st.pslverr = 1'b0;
		end

		if (wr_access && is_ctl) begin
			next_st.cfg[0][`PEC_CTL_FREEZE_BIT] = pwdata[`PEC_CTL_FREEZE_BIT];
		end else if (wr_access && is_cfg) begin
			next_st.cfg[idx[3:0]] = pwdata;
		end

		// Counter words are held inside the counters, not here
		if (wr_access && is_dat && !cnt_hit) begin
			next_st.dat[idx[4:0]] = pwdata;
		end

		// Wrap flags are write-one-to-clear; a wrap in the same cycle wins
		if (wr_access && is_ctl) begin
			next_st.ovf = st.ovf & ~pwdata[`PEC_CTL_OVF_LSB +: NC];
		end
		next_st.ovf = next_st.ovf | cnt_wrap;
	end

	// ----------------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;

endmodule

// ### pec_bank_asserts.sv
// Purpose: Port checks of the counter bank APB slave.
// Assumes: Zero-wait slave, one word per access.
// Notes:   Bound to every pec_bank instance.
`timescale 1ns/10ps
module pec_bank_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic setup;
	logic [3:0] reg_area;
	logic [5:0] reg_idx;
	assign setup = psel && !penable;
	assign reg_area = paddr[11:8];
	assign reg_idx = paddr[7:2];

	ready_after_setup_a: assert property (setup |=> pready) else $error("no ready after setup");
	ready_cause_a: assert property (pready |-> $past(setup)) else $error("ready without setup");
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
	err_with_ready_a: assert property (pslverr |-> pready) else $error("error outside access");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("read data not idle");
	cfg_missing_a: assert property (setup && reg_area == 4'h0 && reg_idx > 6'h0d |=> pslverr)
		else $error("absent config word accepted");
	cfg_present_a: assert property (setup && reg_area == 4'h0 && reg_idx <= 6'h0d && paddr[1:0] == 2'h0
		|=> !pslverr) else $error("present config word refused");
	dat_missing_a: assert property (setup && reg_area == 4'h1 && reg_idx > 6'h11 |=> pslverr)
		else $error("absent count word accepted");
	dat_present_a: assert property (setup && reg_area == 4'h1 && reg_idx <= 6'h11 && paddr[1:0] == 2'h0
		|=> !pslverr) else $error("present count word refused");
	area_missing_a: assert property (setup && reg_area > 4'h1 |=> pslverr) else $error("unmapped area accepted");

	cover property (setup && reg_area == 4'h1);
	cover property (pready && pslverr);
	cover property (setup ##1 pready ##1 setup);
endmodule

bind pec_bank pec_bank_chk pec_bank_chk_i (
	.pclk(pclk),
	.presetn(presetn),
	.paddr(paddr),
	.psel(psel),
	.penable(penable),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr)
);

// ### tb_pec_bank.sv
// Purpose: Self-checking bench of the counter bank.
// Assumes: Zero-wait APB; events sampled every rising edge.
// Notes:   Events idle while counters are configured.
`timescale 1ns/10ps
module tb_pec_bank;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, core_running = 1'h0, core_legacy_isa = 1'h0, evt_valid = 1'h0;
	logic [5:0] retire_valid = 6'h0, retire_rse = 6'h0;
	logic [7:0] evt_code = 8'h0;
	logic [3:0] evt_umask = 4'h0;
	logic [11:0] ma [5] = '{12'h034, 12'h038, 12'h144, 12'h148, 12'h200};
	logic me [5] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h1};
	int errors = 0, tests_run = 0;
	always #10 pclk = ~pclk;
	pec_bank pec_bank_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.core_running(core_running), .core_legacy_isa(core_legacy_isa), .retire_valid(retire_valid),
		.retire_rse(retire_rse), .evt_valid(evt_valid), .evt_code(evt_code), .evt_umask(evt_umask));
	// ----------------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------------
	task end_sim;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Request stands until pready is seen high at a rising edge; the answer is taken at that edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) begin
			n++;
			if (n > 20) begin
				errors++;
				end_sim();
			end
			@(posedge pclk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task rdck(input string nm, input logic [11:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0);
		chk(nm, exp, rd);
	endtask
	// Each lane set retires, two lanes are stack engine work: four counted per cycle
	task ev(input int n, input logic lg, input logic [3:0] um);
		repeat (n) begin
			@(posedge pclk);
			core_running <= 1'h1;
			core_legacy_isa <= lg;
			retire_valid <= 6'h3f;
			retire_rse <= 6'h03;
			evt_valid <= 1'h1;
			evt_code <= 8'h20;
			evt_umask <= um;
		end
		@(posedge pclk);
		core_running <= 1'h0;
		retire_valid <= 6'h00;
		evt_valid <= 1'h0;
	endtask
	// ----------------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------------
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		rdck("ctl_reset", 12'h000, 32'h0);
		apb(1'h1, 12'h010, 32'h0007_0008);
		apb(1'h1, 12'h014, 32'h0007_0008);
		apb(1'h1, 12'h018, 32'h0003_0012);
		apb(1'h1, 12'h01c, 32'h0007_3520);
		apb(1'h1, 12'h020, 32'h0007_0012);
		ev(4, 1'h0, 4'h1);
		ev(4, 1'h1, 4'h2);
		rdck("retired", 12'h110, 32'd32);
		rdck("ret_not_capable", 12'h114, 32'd0);
		rdck("native_cycles", 12'h118, 32'd4);
		rdck("umask_variant", 12'h11c, 32'd4);
		rdck("no_fifth_counter", 12'h120, 32'd0);
		apb(1'h1, 12'h000, 32'h0000_0001);
		ev(3, 1'h0, 4'h1);
		rdck("frozen", 12'h110, 32'd32);
		apb(1'h1, 12'h000, 32'h0000_0000);
		apb(1'h1, 12'h014, 32'h0007_0012);
		apb(1'h1, 12'h110, 32'hffff_fffe);
		ev(1, 1'h0, 4'h0);
		rdck("wrapped", 12'h110, 32'd2);
		rdck("cycles_cnt5", 12'h114, 32'd1);
		rdck("wrap_flag", 12'h000, 32'h0000_0010);
		apb(1'h1, 12'h000, 32'h0000_0010);
		rdck("wrap_clear", 12'h000, 32'h0);
		@(posedge pclk);
		presetn <= 1'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		rdck("cnt_after_reset", 12'h110, 32'h0);
		rdck("cfg_after_reset", 12'h010, 32'h0);
		foreach (ma[i]) begin
			apb(1'h1, ma[i], 32'h0000_5a5a);
			chk("wr_err", {31'h0, me[i]}, {31'h0, er});
			rdck("rd_back", ma[i], me[i] ? 32'h0 : 32'h0000_5a5a);
			chk("rd_err", {31'h0, me[i]}, {31'h0, er});
		end
		end_sim();
	end
endmodule
